/* File: rtl/isoch_ctl_pkg.sv */
package isoch_ctl_pkg;

   // ----------------------------------------------------------------
   // Counts and widths
   // ----------------------------------------------------------------
   localparam int TX_CTX = 8;
   localparam int RX_CTX = 4;
   localparam int CYCLE_W = 13;
   localparam int CHAN_W = 6;
   localparam int FIRST_WORDS = 2;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] TX_PTR_BASE = 12'h20C;
   localparam logic [11:0] TX_PTR_STRIDE = 12'h010;
   localparam logic [11:0] RX_CTL_SET_BASE = 12'h400;
   localparam logic [11:0] RX_CTL_CLR_BASE = 12'h404;
   localparam logic [11:0] RX_START_BASE = 12'h410;
   localparam logic [11:0] RX_STRIDE = 12'h020;

   // ----------------------------------------------------------------
   // Receive control field positions and reset values
   // ----------------------------------------------------------------
   localparam int PACK_FILL_BIT = 31;
   localparam int KEEP_HEADER_BIT = 30;
   localparam int START_ON_CYCLE_BIT = 29;
   localparam int MULTICHANNEL_BIT = 28;
   localparam int SPLIT_PAYLOAD_BIT = 27;
   localparam int RUN_BIT = 15;
   localparam int ACTIVE_BIT = 10;
   localparam int HDR_CHAN_LSB = 8;
   localparam logic [31:0] RX_CTL_RESET = 32'h0000_0000;
   localparam logic [CYCLE_W-1:0] START_CYCLE_RESET = 13'h0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic pack_fill_mode;
      logic keep_header;
      logic start_on_cycle_enable;
      logic multichannel_select;
      logic split_payload_mode;
      logic run;
      logic active;
   } rx_ctl_s;

   typedef struct packed {
      logic valid;
      logic sop;
      logic eop;
      logic [31:0] data;
   } rx_word_s;

   typedef struct packed {
      logic valid;
      logic [1:0] ctx;
      logic secondary;
      logic buf_close;
      logic [31:0] data;
   } dma_wr_s;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_BODY = 4'b0010,
      ST_TRAIL = 4'b0100,
      ST_DROP = 4'b1000
   } rx_st_e;

endpackage

/* File: rtl/rx_context_ctrl.sv */
`timescale 1ns/1ns
module rx_context_ctrl
   import isoch_ctl_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Register writes, already masked by byte lanes
   input wire logic i_set_we,
   input wire logic i_clr_we,
   input wire logic i_start_we,
   input wire logic [31:0] i_wmask,
   // Cycle start events
   input wire logic i_cyc_start,
   input wire logic [CYCLE_W-1:0] i_cyc_count,
   // State
   output rx_ctl_s o_ctl,
   output logic [CYCLE_W-1:0] o_start_cycle
);

   typedef struct packed {
      rx_ctl_s ctl;
      logic [CYCLE_W-1:0] start_cycle;
   } ctx_state_s;

   ctx_state_s s_q;
   ctx_state_s s_d;
   logic busy;

   assign busy = s_q.ctl.run | s_q.ctl.active;

   always_comb
   begin
      s_d = s_q;
      // ----------------------------------------------------------------
      // Software set and clear
      // ----------------------------------------------------------------
      if (i_set_we)
      begin
         s_d.ctl.pack_fill_mode = s_q.ctl.pack_fill_mode | i_wmask[PACK_FILL_BIT];
         s_d.ctl.keep_header = s_q.ctl.keep_header | i_wmask[KEEP_HEADER_BIT];
         s_d.ctl.start_on_cycle_enable =
            s_q.ctl.start_on_cycle_enable | i_wmask[START_ON_CYCLE_BIT];
         s_d.ctl.multichannel_select =
            s_q.ctl.multichannel_select | i_wmask[MULTICHANNEL_BIT];
         if (!busy)
         begin
            s_d.ctl.split_payload_mode = s_q.ctl.split_payload_mode | i_wmask[SPLIT_PAYLOAD_BIT];
         end
         s_d.ctl.run = s_q.ctl.run | i_wmask[RUN_BIT];
      end
      if (i_clr_we)
      begin
         s_d.ctl.pack_fill_mode = s_q.ctl.pack_fill_mode & ~i_wmask[PACK_FILL_BIT];
         s_d.ctl.keep_header = s_q.ctl.keep_header & ~i_wmask[KEEP_HEADER_BIT];
         s_d.ctl.start_on_cycle_enable =
            s_q.ctl.start_on_cycle_enable & ~i_wmask[START_ON_CYCLE_BIT];
         s_d.ctl.multichannel_select =
            s_q.ctl.multichannel_select & ~i_wmask[MULTICHANNEL_BIT];
         if (!busy)
         begin
            s_d.ctl.split_payload_mode = s_q.ctl.split_payload_mode & ~i_wmask[SPLIT_PAYLOAD_BIT];
         end
         s_d.ctl.run = s_q.ctl.run & ~i_wmask[RUN_BIT];
      end
      if (i_start_we)
      begin
         s_d.start_cycle = i_wmask[CYCLE_W-1:0];
      end
      // ----------------------------------------------------------------
      // Hardware updates
      // ----------------------------------------------------------------
      if (s_d.ctl.split_payload_mode)
      begin
         s_d.ctl.pack_fill_mode = 1'b0;
         s_d.ctl.multichannel_select = 1'b0;
      end
      if (!s_q.ctl.run)
      begin
         s_d.ctl.active = 1'b0;
      end
      else if (!s_q.ctl.active)
      begin
         if (!s_q.ctl.start_on_cycle_enable)
         begin
            s_d.ctl.active = 1'b1;
         end
         else if (i_cyc_start && i_cyc_count == s_q.start_cycle)
         begin
            s_d.ctl.active = 1'b1;
         end
      end
      // Hardware clear beats a software set that lands in the same cycle
      if (s_q.ctl.active)
      begin
         s_d.ctl.start_on_cycle_enable = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         s_q <= '{ctl: rx_ctl_s'(7'h00), start_cycle: START_CYCLE_RESET};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_ctl = s_q.ctl;
   assign o_start_cycle = s_q.start_cycle;

endmodule

/* File: rtl/isoch_rx_context_control.sv */
// Our own choice: the Wishbone register port.
`timescale 1ns/1ns
// Behaviour
// - Transmit pointer holds first descriptor address
// - Transmit pointer readable, read-only, reset undefined
// - Transmit pointer n at 20Ch plus 16n
// - Receive control set/clear, 32 bytes apart
// - Pack-fill packs packets, else one per buffer
// - Keep-header stores header, trailer with timestamp
// - Without keep-header, header is stripped
// - Retained header precedes its payload
// - Start-on-cycle waits for matching cycle count
// - Hardware clears start-on-cycle once active
// - Multichannel select accepts masked channels
// - Otherwise accept only the matched channel
// - Split mode sends payload to two chains
// - Split mode forces multichannel, pack-fill zero
// - Split bit frozen while run or active
// - Control bits 26-16 read zero
// - Run changed only by software or reset
// - Active held while processing descriptors
module isoch_rx_context_control
   import isoch_ctl_pkg::*;
#(
   parameter int FIRST_PAYLOAD_WORDS = FIRST_WORDS
)
(
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_ARST_N,
   // Wishbone slave
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [11:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   // Transmit descriptor engine
   input wire logic [TX_CTX-1:0][31:0] I_TX_DESC_PTR,
   // Link receive path
   input rx_word_s I_RX,
   input wire logic [63:0] I_CHAN_MASK,
   input wire logic [RX_CTX-1:0][CHAN_W-1:0] I_MATCH_CHAN,
   input wire logic I_CYC_START,
   input wire logic [CYCLE_W-1:0] I_CYC_COUNT,
   input wire logic [15:0] I_CYCLE_STAMP,
   input wire logic [15:0] I_TRANSFER_STATUS,
   // Buffer writes toward descriptor memory
   output dma_wr_s O_WR,
   output logic [RX_CTX-1:0] O_RX_ACTIVE
);

   typedef struct packed {
      rx_st_e st;
      logic ack;
      logic [31:0] rdat;
      logic [1:0] ctx;
      logic [7:0] cnt;
      dma_wr_s wr;
      logic [RX_CTX-1:0] active;
   } top_state_s;

   top_state_s s_q;
   top_state_s s_d;
   rx_ctl_s ctl [RX_CTX];
   logic [CYCLE_W-1:0] start_cycle [RX_CTX];
   logic [RX_CTX-1:0] set_we;
   logic [RX_CTX-1:0] clr_we;
   logic [RX_CTX-1:0] start_we;
   logic [31:0] wmask;
   logic req;
   logic [31:0] rd_data;
   logic [CHAN_W-1:0] chan;
   logic found;
   logic [1:0] sel_ctx;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Strobe still high in the ack cycle is not taken twice
   assign req = I_WB_CYC & I_WB_STB & ~s_q.ack;
   assign wmask = I_WB_DAT & {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}},
                              {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

   always_comb
   begin
      set_we = '0;
      clr_we = '0;
      start_we = '0;
      for (int i = 0; i < RX_CTX; i++)
      begin
         if (req && I_WB_WE)
         begin
            set_we[i] = I_WB_ADR == RX_CTL_SET_BASE + RX_STRIDE * 12'(i);
            clr_we[i] = I_WB_ADR == RX_CTL_CLR_BASE + RX_STRIDE * 12'(i);
            start_we[i] = I_WB_ADR == RX_START_BASE + RX_STRIDE * 12'(i);
         end
      end
   end

   // ----------------------------------------------------------------
   // Receive contexts
   // ----------------------------------------------------------------
   for (genvar g = 0; g < RX_CTX; g++)
   begin : g_ctx
      rx_context_ctrl u_ctx (
         .i_clk(I_CORE_CLK),
         .i_arst_n(I_ARST_N),
         .i_set_we(set_we[g]),
         .i_clr_we(clr_we[g]),
         .i_start_we(start_we[g]),
         .i_wmask(wmask),
         .i_cyc_start(I_CYC_START),
         .i_cyc_count(I_CYC_COUNT),
         .o_ctl(ctl[g]),
         .o_start_cycle(start_cycle[g])
      );
   end

   // ----------------------------------------------------------------
   // Register read data
   // ----------------------------------------------------------------
   always_comb
   begin
      logic hit;
      hit = 1'b0;
      rd_data = 32'h0000_0000;
      // Unmapped addresses ack with zero data and drop writes
      for (int i = 0; i < TX_CTX; i++)
      begin
         if (I_WB_ADR == TX_PTR_BASE + TX_PTR_STRIDE * 12'(i))
         begin
            rd_data = I_TX_DESC_PTR[i];
         end
      end
      for (int i = 0; i < RX_CTX; i++)
      begin
         hit = I_WB_ADR == RX_CTL_SET_BASE + RX_STRIDE * 12'(i) ||
               I_WB_ADR == RX_CTL_CLR_BASE + RX_STRIDE * 12'(i);
         if (hit)
         begin
            // Bits 26-16 and all unlisted low bits stay zero
            rd_data = RX_CTL_RESET;
            rd_data[PACK_FILL_BIT] = ctl[i].pack_fill_mode;
            rd_data[KEEP_HEADER_BIT] = ctl[i].keep_header;
            rd_data[START_ON_CYCLE_BIT] = ctl[i].start_on_cycle_enable;
            rd_data[MULTICHANNEL_BIT] = ctl[i].multichannel_select;
            rd_data[SPLIT_PAYLOAD_BIT] = ctl[i].split_payload_mode;
            rd_data[RUN_BIT] = ctl[i].run;
            rd_data[ACTIVE_BIT] = ctl[i].active;
         end
         if (I_WB_ADR == RX_START_BASE + RX_STRIDE * 12'(i))
         begin
            rd_data = {{(32 - CYCLE_W){1'b0}}, start_cycle[i]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Packet steering
   // ----------------------------------------------------------------
   assign chan = I_RX.data[HDR_CHAN_LSB +: CHAN_W];

   // Lowest numbered matching context wins
   always_comb
   begin
      found = 1'b0;
      sel_ctx = 2'h0;
      for (int i = RX_CTX - 1; i >= 0; i--)
      begin
         if (ctl[i].active &&
             (ctl[i].multichannel_select ? I_CHAN_MASK[chan] :
              chan == I_MATCH_CHAN[i]))
         begin
            found = 1'b1;
            sel_ctx = 2'(i);
         end
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      rx_ctl_s c;
      c = ctl[s_q.ctx];
      s_d = s_q;
      s_d.ack = req;
      s_d.wr.valid = 1'b0;
      s_d.wr.buf_close = 1'b0;
      for (int i = 0; i < RX_CTX; i++)
      begin
         s_d.active[i] = ctl[i].active;
      end
      if (req && !I_WB_WE)
      begin
         s_d.rdat = rd_data;
      end

      case (s_q.st)
         ST_IDLE:
         begin
            if (I_RX.valid && I_RX.sop)
            begin
               if (found)
               begin
                  c = ctl[sel_ctx];
                  s_d.ctx = sel_ctx;
                  s_d.cnt = 8'h00;
                  // Header goes first, ahead of its payload
                  s_d.wr.valid = c.keep_header;
                  s_d.wr.ctx = sel_ctx;
                  s_d.wr.secondary = 1'b0;
                  s_d.wr.data = I_RX.data;
                  if (!I_RX.eop)
                  begin
                     s_d.st = ST_BODY;
                  end
                  else if (c.keep_header)
                  begin
                     s_d.st = ST_TRAIL;
                  end
               end
               else if (!I_RX.eop)
               begin
                  s_d.st = ST_DROP;
               end
            end
         end
         ST_BODY:
         begin
            if (I_RX.valid)
            begin
               s_d.wr.valid = 1'b1;
               s_d.wr.data = I_RX.data;
               s_d.wr.secondary = c.split_payload_mode &&
                                  32'(s_q.cnt) >= FIRST_PAYLOAD_WORDS;
               if (s_q.cnt != 8'hFF)
               begin
                  s_d.cnt = s_q.cnt + 8'h01;
               end
               if (I_RX.eop)
               begin
                  if (c.keep_header)
                  begin
                     s_d.st = ST_TRAIL;
                  end
                  else
                  begin
                     s_d.wr.buf_close = ~c.pack_fill_mode;
                     s_d.st = ST_IDLE;
                  end
               end
            end
         end
         ST_TRAIL:
         begin
            // Input not sampled here; keep-header senders leave a gap
            s_d.wr.valid = 1'b1;
            s_d.wr.secondary = c.split_payload_mode;
            s_d.wr.data = {I_TRANSFER_STATUS, I_CYCLE_STAMP};
            s_d.wr.buf_close = ~c.pack_fill_mode;
            s_d.st = ST_IDLE;
         end
         ST_DROP:
         begin
            if (I_RX.valid && I_RX.eop)
            begin
               s_d.st = ST_IDLE;
            end
         end
         default:
         begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         s_q <= '{st: ST_IDLE, ack: 1'b0, rdat: 32'h0000_0000, ctx: 2'h0, cnt: 8'h00,
                  wr: dma_wr_s'(0), active: '0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign O_WB_ACK = s_q.ack;
   assign O_WB_DAT = s_q.rdat;
   assign O_WR = s_q.wr;
   assign O_RX_ACTIVE = s_q.active;

endmodule

/* File: verification/isoch_rx_ctl_checker.sv */
`timescale 1ns/1ns
module isoch_rx_ctl_checker
   import isoch_ctl_pkg::*;
(
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_ARST_N,
   // Register bus
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [11:0] I_WB_ADR,
   input wire logic [31:0] O_WB_DAT,
   input wire logic O_WB_ACK,
   // Data paths
   input wire logic [TX_CTX-1:0][31:0] I_TX_DESC_PTR,
   input rx_word_s I_RX,
   input dma_wr_s O_WR
);
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!I_ARST_N);

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack held longer than one cycle");
   ack_time_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
      else $error("request not answered next cycle");
   ack_cause_a: assert property ($rose(O_WB_ACK) |-> $past(I_WB_CYC && I_WB_STB))
      else $error("ack without request");
   rsvd_zero_a: assert property (O_WB_ACK && !$past(I_WB_WE) && $past(I_WB_ADR) >= 12'h400
      |-> O_WB_DAT[26:16] == 11'h000) else $error("reserved bits not zero");
   tx_ptr_a: assert property (O_WB_ACK && !$past(I_WB_WE) && $past(I_WB_ADR) == 12'h27C
      |-> O_WB_DAT == $past(I_TX_DESC_PTR[7])) else $error("last pointer read wrong");
   split_force_a: assert property (O_WB_ACK && !$past(I_WB_WE) && O_WB_DAT[SPLIT_PAYLOAD_BIT]
      && $past(I_WB_ADR) >= 12'h400 |-> !O_WB_DAT[PACK_FILL_BIT] && !O_WB_DAT[MULTICHANNEL_BIT])
      else $error("split mode with pack or multichannel");
   unmapped_read_a: assert property (O_WB_ACK && !$past(I_WB_WE) && $past(I_WB_ADR) == 12'h000
      |-> O_WB_DAT == 32'h0000_0000) else $error("unmapped read not zero");
   wr_cause_a: assert property (O_WR.valid |-> $past(I_RX.valid) || $past(I_RX.valid, 2))
      else $error("buffer write without received word");

   cover property (O_WR.valid && O_WR.secondary);
   cover property (O_WR.valid && O_WR.buf_close);
   cover property (O_WB_ACK && O_WB_DAT[ACTIVE_BIT]);
endmodule

bind isoch_rx_context_control isoch_rx_ctl_checker u_isoch_rx_ctl_checker (
   .I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
   .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
   .I_TX_DESC_PTR(I_TX_DESC_PTR), .I_RX(I_RX), .O_WR(O_WR));

/* File: verification/link_rx_model.sv */
`timescale 1ns/1ns
module link_rx_model
   import isoch_ctl_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Buffer writes
   input dma_wr_s i_wr,
   // Link side
   output rx_word_s o_rx,
   output logic o_cyc_start,
   output logic [CYCLE_W-1:0] o_cyc_count
);
   dma_wr_s got[$];

   initial
   begin
      o_rx = '0;
      o_cyc_start = 1'b0;
      o_cyc_count = '0;
   end

   always @(posedge i_clk)
   begin
      if (i_wr.valid === 1'b1)
         got.push_back(i_wr);
   end

   task automatic word(input logic s, input logic e, input logic [31:0] d);
      @(posedge i_clk);
      o_rx <= '{valid: 1'b1, sop: s, eop: e, data: d};
   endtask

   // Released line shows the inverse so a stale word never looks valid
   task automatic send(input logic [5:0] ch, input int n, input logic [31:0] base);
      word(1'b1, n == 0, {18'h00000, ch, 8'h00});
      for (int i = 0; i < n; i++)
         word(1'b0, i == n - 1, base + 32'(i));
      repeat (4)
      begin
         @(posedge i_clk);
         o_rx <= '{valid: 1'b0, sop: 1'b0, eop: 1'b0, data: ~o_rx.data};
      end
   endtask

   task automatic cycle(input logic [CYCLE_W-1:0] c);
      @(posedge i_clk);
      o_cyc_start <= 1'b1;
      o_cyc_count <= c;
      @(posedge i_clk);
      o_cyc_start <= 1'b0;
      o_cyc_count <= ~c;
   endtask
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ns
module testbench
   import isoch_ctl_pkg::*;
;
   logic core_clk = 1'b0;
   logic arst_n, cyc, stb, we, ack, cs;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, seed, q;
   logic [TX_CTX-1:0][31:0] txp;
   logic [63:0] cmask;
   logic [RX_CTX-1:0][CHAN_W-1:0] mch;
   logic [15:0] stamp, xst;
   logic [CYCLE_W-1:0] cc, sv;
   logic [RX_CTX-1:0] act;
   logic [5:0] ch;
   rx_word_s rx;
   dma_wr_s wr;
   int n_fail = 0;
   int comparisons = 0;

   always #2 core_clk = ~core_clk;

   isoch_rx_context_control u_isoch_rx_context_control (
      .I_CORE_CLK(core_clk), .I_ARST_N(arst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
      .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .I_TX_DESC_PTR(txp), .I_RX(rx), .I_CHAN_MASK(cmask), .I_MATCH_CHAN(mch),
      .I_CYC_START(cs), .I_CYC_COUNT(cc), .I_CYCLE_STAMP(stamp), .I_TRANSFER_STATUS(xst),
      .O_WR(wr), .O_RX_ACTIVE(act));

   link_rx_model u_link_rx_model (.i_clk(core_clk), .i_wr(wr), .o_rx(rx), .o_cyc_start(cs),
      .o_cyc_count(cc));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic dma_wr_s ew(input logic sec, input logic bc, input logic [31:0] d);
      return '{valid: 1'b1, ctx: 2'h0, secondary: sec, buf_close: bc, data: d};
   endfunction

   task automatic summarize();
      if (n_fail == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic fail(input string m);
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
   endtask

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
         fail($sformatf("value %h expected %h", g, e));
   endtask

   task automatic chk_wr(input dma_wr_s g, input dma_wr_s e);
      comparisons++;
      if (g !== e)
         fail($sformatf("buffer write %h expected %h", g, e));
   endtask

   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (t = 0; t < 20 && ack !== 1'b1; t++)
         @(posedge core_clk);
      if (t == 20)
      begin
         fail("bus timeout");
         summarize();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // Header, payload and trailer as the control bits predict
   task automatic pkt(input logic [5:0] ch, input int n, input logic kh, sp, pf, acc);
      dma_wr_s e[$];
      seed = lfsr(seed);
      u_link_rx_model.got.delete();
      u_link_rx_model.send(ch, n, seed);
      if (acc && kh)
         e.push_back(ew(1'b0, 1'b0, {18'h00000, ch, 8'h00}));
      for (int i = 0; i < n && acc; i++)
         e.push_back(ew(sp && i >= FIRST_WORDS, !kh && !pf && i == n - 1, seed + 32'(i)));
      if (acc && kh)
         e.push_back(ew(sp, !pf, {xst, stamp}));
      chk_reg(32'(u_link_rx_model.got.size()), 32'(e.size()));
      foreach (e[i])
         chk_wr(u_link_rx_model.got[i], e[i]);
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      seed = 32'h0000_0024;
      {arst_n, cyc, stb, we, adr, wdat} = '0;
      sel = 4'hF;
      for (int i = 0; i < TX_CTX; i++)
      begin
         seed = lfsr(seed);
         txp[i] = seed;
      end
      mch = seed[23:0];
      cmask = {seed, ~seed};
      {stamp, xst} = lfsr(seed);
      sv = seed[CYCLE_W-1:0];
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      // Enabled channel: upper or lower half of the mask, whichever is set
      ch = {cmask[{1'b1, mch[0][4:0]}], mch[0][4:0]};
      for (int n = 0; n < TX_CTX; n++)
      begin
         wb(1'b0, TX_PTR_BASE + 12'(16 * n), 32'h0000_0000);
         chk_reg(q, txp[n]);
      end
      wb(1'b0, 12'h000, 32'h0000_0000);
      chk_reg(q, 32'h0000_0000);
      for (int n = 0; n < RX_CTX; n++)
      begin
         wb(1'b1, RX_CTL_SET_BASE + 12'(32 * n), 32'hD0FF_0000);
         wb(1'b0, RX_CTL_SET_BASE + 12'(32 * n), 32'h0000_0000);
         chk_reg(q, 32'hD000_0000);
         wb(1'b1, RX_CTL_CLR_BASE + 12'(32 * n), 32'h4000_0000);
         wb(1'b0, RX_CTL_CLR_BASE + 12'(32 * n), 32'h0000_0000);
         chk_reg(q, 32'h9000_0000);
         wb(1'b1, RX_CTL_SET_BASE + 12'(32 * n), 32'h0800_0000);
         wb(1'b0, RX_CTL_SET_BASE + 12'(32 * n), 32'h0000_0000);
         chk_reg(q, 32'h0800_0000);
         wb(1'b1, RX_CTL_CLR_BASE + 12'(32 * n), 32'hFFFF_FFFF);
      end
      wb(1'b1, RX_CTL_SET_BASE, 32'h4000_8000);
      pkt(mch[0], 2, 1'b1, 1'b0, 1'b0, 1'b1);
      pkt(mch[0] ^ 6'h01, 2, 1'b1, 1'b0, 1'b0, 1'b0);
      // Run is cleared before the mode bits change, though only the split bit is frozen while run or active
      wb(1'b1, RX_CTL_CLR_BASE, 32'h0000_8000);
      wb(1'b1, RX_CTL_CLR_BASE, 32'h4000_0000);
      wb(1'b1, RX_CTL_SET_BASE, 32'h8000_8000);
      pkt(mch[0], 3, 1'b0, 1'b0, 1'b1, 1'b1);
      wb(1'b1, RX_CTL_CLR_BASE, 32'h0000_8000);
      wb(1'b1, RX_CTL_SET_BASE, 32'h1000_0000);
      wb(1'b1, RX_CTL_SET_BASE, 32'h0000_8000);
      pkt(ch, 2, 1'b0, 1'b0, 1'b1, 1'b1);
      pkt(ch ^ 6'h20, 2, 1'b0, 1'b0, 1'b1, 1'b0);
      wb(1'b1, RX_CTL_CLR_BASE, 32'h0000_8000);
      wb(1'b1, RX_CTL_CLR_BASE, 32'h9000_0000);
      wb(1'b1, RX_CTL_SET_BASE, 32'h0800_0000);
      wb(1'b1, RX_CTL_SET_BASE, 32'h0000_8000);
      pkt(mch[0], 3, 1'b0, 1'b1, 1'b0, 1'b1);
      wb(1'b1, RX_CTL_CLR_BASE, 32'h0800_0000);
      wb(1'b0, RX_CTL_SET_BASE, 32'h0000_0000);
      chk_reg(q, 32'h0800_8400);
      wb(1'b1, RX_CTL_CLR_BASE, 32'h0000_8000);
      wb(1'b1, RX_CTL_CLR_BASE, 32'h0800_0000);
      wb(1'b1, RX_START_BASE, 32'(sv));
      wb(1'b1, RX_CTL_SET_BASE, 32'h2000_8000);
      u_link_rx_model.cycle(sv ^ 13'h0001);
      wb(1'b0, RX_CTL_SET_BASE, 32'h0000_0000);
      chk_reg(q, 32'h2000_8000);
      u_link_rx_model.cycle(sv);
      repeat (3) @(posedge core_clk);
      wb(1'b0, RX_CTL_CLR_BASE, 32'h0000_0000);
      chk_reg(q, 32'h0000_8400);
      chk_reg(32'(act), 32'h0000_0001);
      wb(1'b1, RX_CTL_CLR_BASE, 32'h0000_8000);
      repeat (3) @(posedge core_clk);
      wb(1'b0, RX_CTL_SET_BASE, 32'h0000_0000);
      chk_reg(q, 32'h0000_0000);
      chk_reg(32'(act), 32'h0000_0000);
      summarize();
   end
endmodule
